// ### verilog/adcsof_top.sv
// Function
// - unipolar result is straight binary, zero input gives all zeros
// - bipolar result is two's complement, most positive 0111111111
// - sixth config bit: one sends msb first, zero lsb first
// - bit order from a config word applies to the next output word
// - config word is always received in the same fixed bit order
// - last two config bits select 8, 10, 12 or 16 bit output
// - word length applies to the word shifted in the same transfer
// - chip select changes shorter than one conversion clock are ignored
// - chip select change accepted after two conversion clock falling edges
// - accepted low chip select enables the data output driver
// - shift clock ignored while chip select is high
// - with select held low, first bit driven once conversion completes
// - data changes on falling shift edge, sampled on rising edge
// - config captured on first eight rising edges, rest ignored
// - output positions beyond the ten result bits are zero
// - fifth config bit: one unipolar, zero bipolar conversion
module adcsof_top (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// serial pins
	input wire logic cs_n,
	input wire logic aclk,
	input wire logic sclk,
	input wire logic din,
	output logic dout,
	output logic dout_oe_n,
	// converter core
	output logic conv_start,
	output logic single_ended_select,
	output logic [2:0] chan_sel,
	output logic unipolar_select,
	input wire logic conv_done,
	input wire logic [adcsof_pkg::RES_W-1:0] conv_code,
	// status
	output logic conv_busy
);
	// ********************************
	// declarations
	// ********************************
	adcsof_cs_if cs_bus ();
	adcsof_pkg::adcsof_state_t state_reg;
	logic cs_valid_n;
	logic frame_active;
	logic link_rst;
	logic [adcsof_pkg::CNT_W-1:0] rise_cnt_reg;
	logic [adcsof_pkg::CNT_W-1:0] fall_cnt_reg;
	logic [adcsof_pkg::CFG_W-1:0] cfg_reg;
	logic [adcsof_pkg::CFG_W-1:0] cfg_next;
	logic [adcsof_pkg::CFG_W-1:0] cfg_lk_reg;
	logic [adcsof_pkg::CNT_W-1:0] len_cur;
	logic [adcsof_pkg::CNT_W-1:0] len_live;
	logic [adcsof_pkg::CNT_W-1:0] rise_cnt_next;
	logic xfer_done_reg;
	logic done_tgl_reg;
	logic tg_s1_reg;
	logic tg_s2_reg;
	logic tg_s3_reg;
	logic xfer_evt;
	logic order_reg;
	logic conv_start_reg;
	logic busy_reg;
	logic conv_uni_reg;
	logic [adcsof_pkg::RES_W-1:0] result_reg;
	logic [adcsof_pkg::WORD_W-1:0] out_seq;

	// ********************************
	// chip select deglitcher
	// ********************************
	assign cs_bus.cs_n_raw = cs_n;
	assign cs_bus.aclk_raw = aclk;
	assign cs_valid_n = cs_bus.cs_n_valid;

	adcsof_deglitch u_deglitch (
		.clk(clk),
		.rst(rst),
		.cs(cs_bus.filt)
	);

	// ********************************
	// link control state
	// ********************************
	// wait out conversion before driving
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= adcsof_pkg::LINK_OFF;
		end else begin
			case (state_reg)
				adcsof_pkg::LINK_OFF: begin
					if (!cs_valid_n && !busy_reg && !conv_start_reg) begin
						state_reg <= adcsof_pkg::LINK_ACTIVE;
					end
				end
				adcsof_pkg::LINK_ACTIVE: begin
					if (cs_valid_n) begin
						state_reg <= adcsof_pkg::LINK_OFF;
					end else if (xfer_evt) begin
						state_reg <= adcsof_pkg::LINK_DONE;
					end
				end
				adcsof_pkg::LINK_DONE: begin
					if (cs_valid_n) begin
						state_reg <= adcsof_pkg::LINK_OFF;
					end else if (!busy_reg && !conv_start_reg) begin
						state_reg <= adcsof_pkg::LINK_ACTIVE;
					end
				end
				default: begin
					state_reg <= adcsof_pkg::LINK_OFF;
				end
			endcase
		end
	end

	assign frame_active = (state_reg == adcsof_pkg::LINK_ACTIVE);
	// link logic held cleared outside a frame; sclk is assumed idle low at release
	// shift clock ignored when deselected
	// relies on sclk low in conversion
	assign link_rst = rst | ~frame_active;
	// drive only on accepted select
	// select drop releases the line at once, before the state follows
	assign dout_oe_n = ~frame_active | cs_valid_n;

	// ********************************
	// link side: input capture
	// ********************************
	// fixed msb-first config shifting
	assign cfg_next = {cfg_reg[adcsof_pkg::CFG_W-2:0], din};
	assign rise_cnt_next = rise_cnt_reg + adcsof_pkg::CNT_ONE;
	assign len_live = adcsof_pkg::adcsof_len({cfg_reg[adcsof_pkg::CFG_WLH_BIT], cfg_reg[adcsof_pkg::CFG_WLL_BIT]});
	assign len_cur = (rise_cnt_reg == adcsof_pkg::CFG_LAST_IDX) ?
		adcsof_pkg::adcsof_len({cfg_next[adcsof_pkg::CFG_WLH_BIT], cfg_next[adcsof_pkg::CFG_WLL_BIT]}) : len_live;

	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			cfg_reg <= adcsof_pkg::CFG_RST;
		end else if (!link_rst && rise_cnt_reg < adcsof_pkg::LEN_8) begin
			cfg_reg <= cfg_next;
		end
	end

	always_ff @(posedge sclk or posedge link_rst) begin
		if (link_rst) begin
			rise_cnt_reg <= adcsof_pkg::CNT_ZERO;
			xfer_done_reg <= 1'b0;
		end else if (!xfer_done_reg) begin
			rise_cnt_reg <= rise_cnt_next;
			if (rise_cnt_next == len_cur) begin
				xfer_done_reg <= 1'b1;
			end
		end
	end

	// toggle survives the frame clear so the event is not lost
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			done_tgl_reg <= 1'b0;
		end else if (!link_rst && !xfer_done_reg && rise_cnt_next == len_cur) begin
			done_tgl_reg <= ~done_tgl_reg;
		end
	end

	// ********************************
	// link side: output shifting
	// ********************************
	// advance output on falling edge
	always_ff @(negedge sclk or posedge link_rst) begin
		if (link_rst) begin
			fall_cnt_reg <= adcsof_pkg::CNT_ZERO;
		end else if (fall_cnt_reg < adcsof_pkg::LEN_16) begin
			fall_cnt_reg <= fall_cnt_reg + adcsof_pkg::CNT_ONE;
		end
	end

	// word bits are static during a frame, so the mux is safe across domains
	// stop after selected length
	always_comb begin
		dout = 1'b0;
		if (fall_cnt_reg < adcsof_pkg::LEN_8 || fall_cnt_reg < len_live) begin
			dout = out_seq[fall_cnt_reg[3:0]];
		end
	end

	// ********************************
	// exchange event crossing
	// ********************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tg_s1_reg <= 1'b0;
			tg_s2_reg <= 1'b0;
			tg_s3_reg <= 1'b0;
		end else begin
			tg_s1_reg <= done_tgl_reg;
			tg_s2_reg <= tg_s1_reg;
			tg_s3_reg <= tg_s2_reg;
		end
	end

	assign xfer_evt = tg_s2_reg ^ tg_s3_reg;

	// ********************************
	// configuration latch
	// ********************************
	// order held for next word
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_lk_reg <= adcsof_pkg::CFG_RST;
			order_reg <= adcsof_pkg::ORDER_RST;
		end else if (xfer_evt && frame_active) begin
			cfg_lk_reg <= cfg_reg;
			order_reg <= cfg_reg[adcsof_pkg::CFG_MSB_FIRST_SELECT_BIT];
		end
	end

	assign unipolar_select = cfg_lk_reg[adcsof_pkg::CFG_UNI_BIT];
	assign single_ended_select = cfg_lk_reg[adcsof_pkg::CFG_SGL_BIT];
	assign chan_sel = {cfg_lk_reg[adcsof_pkg::CFG_ODD_BIT], cfg_lk_reg[adcsof_pkg::CFG_SEL1_BIT],
		cfg_lk_reg[adcsof_pkg::CFG_SEL0_BIT]};

	// ********************************
	// conversion control
	// ********************************
	// start at end of exchange
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conv_start_reg <= 1'b0;
		end else begin
			conv_start_reg <= xfer_evt && frame_active;
		end
	end

	// set wins over the done clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_reg <= 1'b0;
		end else if (conv_start_reg) begin
			busy_reg <= 1'b1;
		end else if (conv_done) begin
			busy_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conv_uni_reg <= 1'b1;
		end else if (conv_start_reg) begin
			conv_uni_reg <= cfg_lk_reg[adcsof_pkg::CFG_UNI_BIT];
		end
	end

	assign conv_start = conv_start_reg;
	assign conv_busy = busy_reg;

	// ********************************
	// result formatting
	// ********************************
	// core code is offset binary; bipolar flips the top bit
	// unipolar straight binary
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			result_reg <= adcsof_pkg::RES_RST;
		end else if (conv_done && busy_reg) begin
			result_reg <= conv_uni_reg ? conv_code : (conv_code ^ adcsof_pkg::BIP_FLIP);
		end
	end

	always_comb begin
		out_seq = '0;
		for (int i = 0; i < adcsof_pkg::RES_W; i++) begin
			out_seq[i] = order_reg ? result_reg[adcsof_pkg::RES_W-1-i] : result_reg[i];
		end
	end

	// ********************************
	// checks
	// ********************************
	a_start_after_xfer: assert property (@(posedge clk) disable iff (rst)
		xfer_evt && frame_active |=> conv_start ##1 conv_busy)
		else $error("conversion did not start after exchange");
	a_drive_needs_select: assert property (@(posedge clk) disable iff (rst)
		!dout_oe_n |-> !cs_valid_n)
		else $error("data output driven without accepted select");
	a_no_drive_busy: assert property (@(posedge clk) disable iff (rst)
		conv_busy |-> dout_oe_n)
		else $error("data output driven during conversion");
	a_order_next_word: assert property (@(posedge clk) disable iff (rst)
		xfer_evt && frame_active |=> order_reg == $past(cfg_reg[adcsof_pkg::CFG_MSB_FIRST_SELECT_BIT]))
		else $error("bit order not taken from last config word");
	a_unipolar_code: assert property (@(posedge clk) disable iff (rst)
		conv_done && busy_reg && conv_uni_reg |=> result_reg == $past(conv_code))
		else $error("unipolar result not straight binary");
	a_bipolar_code: assert property (@(posedge clk) disable iff (rst)
		conv_done && busy_reg && !conv_uni_reg |=> result_reg == ($past(conv_code) ^ 10'h200))
		else $error("bipolar result not two's complement");
	a_msb_first_seq: assert property (@(posedge clk) disable iff (rst)
		order_reg |-> out_seq[0] == result_reg[9] && out_seq[9] == result_reg[0])
		else $error("msb first order wrong");
	a_lsb_first_seq: assert property (@(posedge clk) disable iff (rst)
		!order_reg |-> out_seq[0] == result_reg[0] && out_seq[9] == result_reg[9])
		else $error("lsb first order wrong");
	a_zero_fill: assert property (@(posedge clk) disable iff (rst)
		out_seq[15:10] == 6'h00)
		else $error("trailing positions not zero");
	a_uni_to_core: assert property (@(posedge clk) disable iff (rst)
		conv_start |=> conv_uni_reg == unipolar_select)
		else $error("conversion type not passed to core");
	a_wait_then_drive: assert property (@(posedge clk) disable iff (rst)
		state_reg == adcsof_pkg::LINK_DONE && !cs_valid_n && $fell(conv_busy) |=> !dout_oe_n || cs_valid_n)
		else $error("select held low but output not driven after conversion");
	a_quiet_after_xfer: assert property (@(posedge clk) disable iff (rst)
		xfer_evt && frame_active |=> dout_oe_n)
		else $error("output still driven after exchange end");
	a_busy_clears: assert property (@(posedge clk) disable iff (rst)
		conv_done && busy_reg && !conv_start_reg |=> !conv_busy)
		else $error("busy not cleared by conversion done");
	a_config_latch: assert property (@(posedge clk) disable iff (rst)
		xfer_evt && frame_active |=> unipolar_select == $past(cfg_reg[adcsof_pkg::CFG_UNI_BIT]))
		else $error("conversion type not taken from config word");

	c_bipolar_result: cover property (@(posedge clk) disable iff (rst)
		conv_done && busy_reg && !conv_uni_reg);
	c_select_low_conv: cover property (@(posedge clk) disable iff (rst)
		state_reg == adcsof_pkg::LINK_DONE ##1 state_reg == adcsof_pkg::LINK_ACTIVE);
	c_lsb_first: cover property (@(posedge clk) disable iff (rst)
		xfer_evt && frame_active && !cfg_reg[adcsof_pkg::CFG_MSB_FIRST_SELECT_BIT]);
	c_short_word: cover property (@(posedge clk) disable iff (rst)
		xfer_evt && frame_active && {cfg_reg[adcsof_pkg::CFG_WLH_BIT], cfg_reg[adcsof_pkg::CFG_WLL_BIT]} == 2'h0);
	c_long_word: cover property (@(posedge clk) disable iff (rst)
		xfer_evt && frame_active && {cfg_reg[adcsof_pkg::CFG_WLH_BIT], cfg_reg[adcsof_pkg::CFG_WLL_BIT]} == 2'h3);
endmodule : adcsof_top

// ### verilog/adcsof_pkg.sv
package adcsof_pkg;
	// ********************************
	// widths
	// ********************************
	localparam int CFG_W = 8;
	localparam int RES_W = 10;
	localparam int WORD_W = 16;
	localparam int CNT_W = 5;

	// ********************************
	// configuration word fields, first bit received lands in bit 7
	// ********************************
	localparam int CFG_SGL_BIT = 7;
	localparam int CFG_ODD_BIT = 6;
	localparam int CFG_SEL1_BIT = 5;
	localparam int CFG_SEL0_BIT = 4;
	localparam int CFG_UNI_BIT = 3;
	localparam int CFG_MSB_FIRST_SELECT_BIT = 2;
	localparam int CFG_WLH_BIT = 1;
	localparam int CFG_WLL_BIT = 0;

	// ********************************
	// word lengths and counts
	// ********************************
	localparam logic [CNT_W-1:0] LEN_8 = 5'h08;
	localparam logic [CNT_W-1:0] LEN_10 = 5'h0a;
	localparam logic [CNT_W-1:0] LEN_12 = 5'h0c;
	localparam logic [CNT_W-1:0] LEN_16 = 5'h10;
	localparam logic [CNT_W-1:0] CFG_LAST_IDX = 5'h07;
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
	localparam logic [1:0] DEGL_LAST_FALL = 2'h1;

	// ********************************
	// reset values and coding
	// ********************************
	localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
	localparam logic [RES_W-1:0] RES_RST = 10'h000;
	localparam logic ORDER_RST = 1'b1;
	localparam logic [RES_W-1:0] BIP_FLIP = 10'h200;

	typedef enum logic [1:0] {
		LINK_OFF,
		LINK_ACTIVE,
		LINK_DONE
	} adcsof_state_t;

	function automatic logic [CNT_W-1:0] adcsof_len(input logic [1:0] wl);
		logic [CNT_W-1:0] len;
		len = LEN_8;
		case (wl)
			2'h0: len = LEN_8;
			2'h1: len = LEN_10;
			2'h2: len = LEN_12;
			default: len = LEN_16;
		endcase
		return len;
	endfunction : adcsof_len
endpackage : adcsof_pkg

// ### verilog/adcsof_cs_if.sv
interface adcsof_cs_if;
	logic cs_n_raw;
	logic aclk_raw;
	logic cs_n_valid;

	modport filt (
		input cs_n_raw,
		input aclk_raw,
		output cs_n_valid
	);
	modport ctrl (
		output cs_n_raw,
		output aclk_raw,
		input cs_n_valid
	);
endinterface : adcsof_cs_if

// ### verilog/adcsof_deglitch.sv
module adcsof_deglitch (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// chip select path
	adcsof_cs_if.filt cs
);
	logic cs_s1_reg;
	logic cs_s2_reg;
	logic ak_s1_reg;
	logic ak_s2_reg;
	logic ak_s3_reg;
	logic valid_reg;
	logic [1:0] fall_cnt_reg;
	logic aclk_fall;

	// ********************************
	// synchronisers
	// ********************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			ak_s1_reg <= 1'b0;
			ak_s2_reg <= 1'b0;
			ak_s3_reg <= 1'b0;
		end else begin
			cs_s1_reg <= cs.cs_n_raw;
			cs_s2_reg <= cs_s1_reg;
			ak_s1_reg <= cs.aclk_raw;
			ak_s2_reg <= ak_s1_reg;
			ak_s3_reg <= ak_s2_reg;
		end
	end

	assign aclk_fall = ak_s3_reg & ~ak_s2_reg;

	// ********************************
	// filter
	// ********************************
	// short changes dropped
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			valid_reg <= 1'b1;
			fall_cnt_reg <= 2'h0;
		end else if (cs_s2_reg == valid_reg) begin
			fall_cnt_reg <= 2'h0;
		end else if (aclk_fall) begin
			if (fall_cnt_reg == adcsof_pkg::DEGL_LAST_FALL) begin
				valid_reg <= cs_s2_reg;
				fall_cnt_reg <= 2'h0;
			end else begin
				fall_cnt_reg <= fall_cnt_reg + 2'h1;
			end
		end
	end

	assign cs.cs_n_valid = valid_reg;

	// ********************************
	// checks
	// ********************************
	a_valid_needs_falls: assert property (@(posedge clk) disable iff (rst)
		$changed(valid_reg) |-> $past(aclk_fall) && $past(fall_cnt_reg) == 2'h1)
		else $error("chip select accepted without two conversion clock falls");
	a_valid_follows_pin: assert property (@(posedge clk) disable iff (rst)
		$changed(valid_reg) |-> valid_reg == $past(cs_s2_reg))
		else $error("accepted chip select differs from stable pin level");
endmodule : adcsof_deglitch

// ### test/adcsof_host.sv
module adcsof_host (
	// pins to the block
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire logic dout,
	input wire logic dout_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end

	// ****
	// one exchange, 30 ns shift clock
	// ****
	task automatic xfer(input logic [7:0] cfg, input int n, input bit hold, output logic [15:0] got,
		output bit ok);
		int t;
		got = 16'h0000;
		cs_n = 1'b0;
		t = 0;
		while (dout_oe_n !== 1'b0 && t < 400) begin
			#10;
			t++;
		end
		ok = (t < 400);
		for (int i = 0; i < n; i++) begin
			din = (i < 8) ? cfg[7 - i] : ~din;
			#15;
			// bit settled before rise
			// released line reads as garbage, here the inverse
			got[i] = dout_oe_n ? ~dout : dout;
			sclk = 1'b1;
			#15;
			sclk = 1'b0;
		end
		din = ~din;
		if (!hold) begin
			cs_n = 1'b1;
			#1000;
		end
	endtask : xfer

	task automatic pulse(input int len);
		cs_n = 1'b0;
		#(len);
		cs_n = 1'b1;
		#1000;
	endtask : pulse

	// deliberate shifting while deselected
	task automatic noise(input int n);
		repeat (n) begin
			#15 sclk = 1'b1;
			#15 sclk = 1'b0;
		end
	endtask : noise
endmodule : adcsof_host

// ### test/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic aclk = 1'b0;
	logic conv_done = 1'b0;
	logic [adcsof_pkg::RES_W-1:0] conv_code = 10'h000;
	logic cs_n, sclk, din, dout, dout_oe_n, conv_start, single_ended_select, unipolar_select, conv_busy;
	logic [2:0] chan_sel;
	logic [9:0] core_code = 10'h000;
	logic [9:0] exp_res = 10'h000;
	logic [7:0] prev_cfg = 8'h04;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	int wait_cnt = 0;

	always #25 clk = ~clk;
	// conversion clock unrelated to clk
	always #100 aclk = ~aclk;

	adcsof_top dut (.clk(clk), .rst(rst), .cs_n(cs_n), .aclk(aclk), .sclk(sclk), .din(din), .dout(dout),
		.dout_oe_n(dout_oe_n), .conv_start(conv_start), .single_ended_select(single_ended_select),
		.chan_sel(chan_sel), .unipolar_select(unipolar_select), .conv_done(conv_done),
		.conv_code(conv_code), .conv_busy(conv_busy));
	adcsof_host host (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe_n(dout_oe_n));

	// ****
	// converter core, long enough to outlast the deselect gap
	// ****
	always @(posedge clk) begin
		conv_done <= (wait_cnt == 1);
		conv_code <= core_code;
		if (conv_start === 1'b1)
			wait_cnt <= 40;
		else if (wait_cnt > 0)
			wait_cnt <= wait_cnt - 1;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			conclude();
		end
	end

	// ****
	// helpers
	// ****
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	// first bit out lands in bit 0, zeros past the result
	function automatic logic [15:0] word(input logic [9:0] r, input logic [7:0] pc, input int n);
		logic [15:0] w;
		w = 16'h0000;
		for (int k = 0; k < 10; k++)
			if (k < n)
				w[k] = pc[2] ? r[9 - k] : r[k];
		return w;
	endfunction : word

	task automatic run(input logic [7:0] cfg, input logic [9:0] code, input bit hold);
		logic [15:0] got;
		bit ok;
		int n;
		int t;
		n = (cfg[1:0] == 2'h0) ? 8 : (cfg[1:0] == 2'h1) ? 10 : (cfg[1:0] == 2'h2) ? 12 : 16;
		core_code = code;
		host.xfer(cfg, n, hold, got, ok);
		check({15'h0, ok}, 16'h1, "select accepted");
		check(got, word(exp_res, prev_cfg, n), "result word");
		t = 0;
		while (conv_busy !== 1'b1 && t < 60) begin
			@(negedge clk);
			t++;
		end
		check({11'h0, single_ended_select, chan_sel, unipolar_select}, {11'h0, cfg[7:3]}, "config");
		if (hold)
			check({15'h0, dout_oe_n}, 16'h1, "quiet while converting");
		while (conv_busy !== 1'b0 && t < 200) begin
			@(negedge clk);
			t++;
		end
		check({15'h0, t < 60}, 16'h1, "conversion ended");
		exp_res = cfg[3] ? code : code ^ 10'h200;
		prev_cfg = cfg;
	endtask : run

	// ****
	// scenarios
	// ****
	task automatic t_reset;
		@(negedge clk);
		check({12'h0, dout_oe_n, conv_start, conv_busy, unipolar_select}, 16'h8, "reset state");
		$display("test reset done");
	endtask : t_reset

	task automatic t_formats;
		logic [7:0] cfgs [8] = '{8'h8f, 8'h78, 8'h35, 8'hca, 8'h1e, 8'he1, 8'h54, 8'hab};
		logic [9:0] codes [8] = '{10'h001, 10'h3ff, 10'h3ff, 10'h000, 10'h2aa, 10'h200, 10'h1ff, 10'h155};
		// each word read back one transfer later in its own order and coding
		for (int i = 0; i < 8; i++)
			run(cfgs[i], codes[i], 1'b0);
		$display("test formats done");
	endtask : t_formats

	task automatic t_sclk_idle;
		host.noise(12);
		check({15'h0, dout_oe_n}, 16'h1, "no drive while deselected");
		run(8'h8f, 10'h001, 1'b0);
		$display("test sclk idle done");
	endtask : t_sclk_idle

	task automatic t_glitch;
		host.pulse(80);
		repeat (16) begin
			@(negedge clk);
			check({15'h0, dout_oe_n}, 16'h1, "short select ignored");
		end
		run(8'h8d, 10'h3ff, 1'b0);
		$display("test glitch done");
	endtask : t_glitch

	task automatic t_hold_low;
		logic [15:0] w;
		int t;
		run(8'h1d, 10'h2ff, 1'b1);
		t = 0;
		while (dout_oe_n !== 1'b0 && t < 20) begin
			@(negedge clk);
			t++;
		end
		w = word(exp_res, prev_cfg, 10);
		check({14'h0, dout_oe_n, dout}, {15'h0, w[0]}, "first bit after conversion");
		run(8'h18, 10'h000, 1'b0);
		run(8'h1f, 10'h000, 1'b0);
		$display("test hold low done");
	endtask : t_hold_low

	task automatic conclude;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_formats();
		t_sclk_idle();
		t_glitch();
		t_hold_low();
		conclude();
	end
endmodule : tb_top
